/* include/fanout_ctrl_pkg.sv */
// constants and types for the fanout output enable controller
package fanout_ctrl_pkg;
  localparam int N_OUT = 20;
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_STABLE_NS = 1800000;
  localparam int STABLE_CYCLES = T_STABLE_NS / CLK_PERIOD_NS;
  localparam int ENABLE_MAX_PERIODS = 10;
  localparam logic [2:0] HOLD_CLOCKS = 3'h4;
  localparam logic [7:0] MAX_COUNT = 8'h20;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // register indexes
  localparam logic [6:0] REG_OE0 = 7'h00;
  localparam logic [6:0] REG_OE1 = 7'h01;
  localparam logic [6:0] REG_OE2 = 7'h02;
  localparam logic [6:0] REG_PINS = 7'h03;
  localparam logic [6:0] REG_SIDEBAND_ENABLE = 7'h04;
  localparam logic [6:0] REG_ID = 7'h06;
  localparam logic [6:0] REG_BCNT = 7'h07;
  localparam logic [6:0] REG_MASK0 = 7'h08;
  localparam logic [6:0] REG_MASK1 = 7'h09;
  localparam logic [6:0] REG_MASK2 = 7'h0a;
  // field positions: byte 0 bits 6:3 drive outputs 19:16
  localparam int OE0_LSB = 3;
  // reset values
  localparam logic [19:0] OE_RESET = 20'hfffff;
  localparam logic [19:0] SB_RESET = 20'hfffff;
  localparam logic [19:0] MASK_RESET = 20'h00000;
  localparam logic [7:0] BCNT_RESET = 8'h08;
  // tri-level strap codes
  localparam logic [1:0] TRI_L = 2'h0;
  localparam logic [1:0] TRI_M = 2'h1;
  localparam logic [1:0] TRI_H = 2'h2;
  typedef enum logic [5:0] {
    SM_IDLE = 6'h01,
    SM_ADDR = 6'h02,
    SM_CMD  = 6'h04,
    SM_CNT  = 6'h08,
    SM_WR   = 6'h10,
    SM_RD   = 6'h20
  } smb_state_t;
endpackage

/* design/fanout_ctrl.sv */
// output enable, power sequencing, smbus client and side-band link of the fanout buffer
`timescale 1ns/100ps
// Summary of operation
// - an enable pin going low restarts its output within ten reference periods
// - an enable pin going high keeps four clocks then stops within ten periods
// - outside side-band mode, output runs only with register bit one, pin zero and power good high
// - the eight enable pins govern outputs five to twelve only
// - first power good rise latches the tri-level address straps
// - after that, power good low forces all outputs low and power saving
// - power good low, once through the two-flop synchroniser, disables all outputs next clock
// - outputs are stable well within 1.8 ms of power good rising
// - nine strap combinations select nine client addresses
// - command bit seven picks single byte access, clear picks block access
// - block count must lie between one and thirty two
// - block write: low seven command bits give first index, then count, data
// - block read returns count then data until the host answers nack
// - every write data byte is acknowledged; a wrong address or bad block count is not
// - with load high each side-band clock rise shifts in the data level
// - load falling copies the shift register into the output register, in side-band mode only
// - side-band enable swaps pins and register enables for the serial path
// - a set mask bit forces its output enabled in side-band mode
// - side-band shifting and loading work while power good is low
// - no smbus response while power good is low
// - output and side-band enables default to all enabled
// - load low makes the device ignore side-band clock and data
module fanout_ctrl
  import fanout_ctrl_pkg::*;
(
  // system
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // power and straps
  input  wire logic        power_good,
  input  wire logic [1:0]  addr_select_0,
  input  wire logic [1:0]  addr_select_1,
  input  wire logic        sideband_enable,
  // enable pins; pins 5, 6, 10 double as side-band data, clock, load
  input  wire logic        enable_pin_5_n,
  input  wire logic        enable_pin_6_n,
  input  wire logic        enable_pin_10_n,
  input  wire logic [4:0]  enable_pin_other_n,
  // smbus
  input  wire logic        smb_clock,
  input  wire logic        smb_data_in,
  output logic             smb_data_out,
  output logic             smb_data_oe,
  // output gating
  output logic [19:0]      clk_enable,
  output logic             power_save
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [7:0] addr_lookup(input logic [1:0] s1, input logic [1:0] s0);
    logic [3:0] k;
    k = {s1, s0};
    case (k)
      {TRI_L, TRI_L}: addr_lookup = 8'hd8;
      {TRI_L, TRI_M}: addr_lookup = 8'hda;
      {TRI_L, TRI_H}: addr_lookup = 8'hde;
      {TRI_M, TRI_L}: addr_lookup = 8'hc2;
      {TRI_M, TRI_M}: addr_lookup = 8'hc4;
      {TRI_M, TRI_H}: addr_lookup = 8'hc6;
      {TRI_H, TRI_L}: addr_lookup = 8'hca;
      {TRI_H, TRI_M}: addr_lookup = 8'hcc;
      default:        addr_lookup = 8'hce;
    endcase
  endfunction

  // ****************************************
  // synchronisers
  // ****************************************
  localparam logic [7:0] DEVICE_ID = 8'h5a; // arbitrary value
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic [7:0]  pins_s;
  logic        pg_s;
  logic        sideband_enable_s;
  logic        scl_s;
  logic        sda_s;
  logic [1:0]  sa0_s;
  logic [1:0]  sa1_s;

  always_ff @(posedge sys_clk) begin
    sync1_r <= {addr_select_1, addr_select_0, power_good, sideband_enable, smb_clock,
                smb_data_in, enable_pin_other_n[4:3], enable_pin_10_n,
                enable_pin_other_n[2:0], enable_pin_6_n, enable_pin_5_n};
    sync2_r <= sync1_r;
  end

  assign pins_s = sync2_r[7:0];
  assign sda_s  = sync2_r[8];
  assign scl_s  = sync2_r[9];
  assign sideband_enable_s = sync2_r[10];
  assign pg_s   = sync2_r[11];
  assign sa0_s  = sync2_r[13:12];
  assign sa1_s  = sync2_r[15:14];

  // ****************************************
  // strap latch
  // ****************************************
  logic       pg_seen_r;
  logic [7:0] addr_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pg_seen_r <= 1'b0;
      addr_r    <= 8'h00;
    end else if (pg_s && !pg_seen_r) begin
      pg_seen_r <= 1'b1;
      addr_r    <= addr_lookup(sa1_s, sa0_s);
    end
  end

  // ****************************************
  // side-band link
  // ****************************************
  logic [19:0] sb_shift_r;
  logic [19:0] sb_out_r;
  logic        ld_prev_r;
  logic        ld_fall_w;

  always_ff @(posedge enable_pin_6_n) begin
    if (enable_pin_10_n) begin
      sb_shift_r <= {enable_pin_5_n, sb_shift_r[19:1]};
    end
  end

  assign ld_fall_w = ld_prev_r && !pins_s[5];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ld_prev_r <= 1'b0;
      sb_out_r  <= SB_RESET;
    end else begin
      ld_prev_r <= pins_s[5];
      if (ld_fall_w && sideband_enable_s) begin
        sb_out_r <= sb_shift_r;
      end
    end
  end

  // ****************************************
  // smbus client
  // ****************************************
  smb_state_t  state_r;
  logic        scl_prev_r;
  logic        sda_prev_r;
  logic [3:0]  bit_cnt_r;
  logic        ack_r;
  logic        sda_oe_r;
  logic [7:0]  shreg_r;
  logic [7:0]  tx_r;
  logic [6:0]  idx_r;
  logic        single_r;
  logic        first_r;
  logic [7:0]  left_r;
  logic [19:0] oe_r;
  logic [19:0] mask_r;
  logic [7:0]  bcnt_r;
  logic        start_w;
  logic        stop_w;
  logic        scl_rise_w;
  logic        scl_fall_w;
  logic        byte_done_w;
  logic        wr_en_w;
  logic        cnt_ok_w;
  logic [7:0]  next_tx_w;

  function automatic logic [7:0] rd_byte(input logic [6:0] idx);
    case (idx)
      REG_OE0:   rd_byte = {1'b0, oe_r[19:16], 3'h0};
      REG_OE1:   rd_byte = oe_r[7:0];
      REG_OE2:   rd_byte = oe_r[15:8];
      REG_PINS:  rd_byte = pins_s;
      REG_SIDEBAND_ENABLE:  rd_byte = {7'h00, sideband_enable_s};
      REG_ID:    rd_byte = DEVICE_ID;
      REG_BCNT:  rd_byte = bcnt_r;
      REG_MASK0: rd_byte = mask_r[7:0];
      REG_MASK1: rd_byte = mask_r[15:8];
      REG_MASK2: rd_byte = {4'h0, mask_r[19:16]};
      default:   rd_byte = 8'h00;
    endcase
  endfunction

  assign start_w     = scl_s && scl_prev_r && sda_prev_r && !sda_s;
  assign stop_w      = scl_s && scl_prev_r && !sda_prev_r && sda_s;
  assign scl_rise_w  = scl_s && !scl_prev_r;
  assign scl_fall_w  = !scl_s && scl_prev_r;
  assign byte_done_w = scl_fall_w && (bit_cnt_r == BITS_PER_BYTE) && !ack_r;
  assign cnt_ok_w    = (shreg_r != 8'h00) && (shreg_r <= MAX_COUNT);
  assign wr_en_w     = pg_s && byte_done_w && (state_r == SM_WR) && (left_r != 8'h00);
  assign next_tx_w   = (!single_r && first_r) ? bcnt_r : rd_byte(idx_r);

  always_ff @(posedge sys_clk) begin
    scl_prev_r <= scl_s;
    sda_prev_r <= sda_s;
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !pg_s) begin
      state_r   <= SM_IDLE;
      bit_cnt_r <= 4'h0;
      ack_r     <= 1'b0;
      sda_oe_r  <= 1'b0;
      shreg_r   <= 8'h00;
      tx_r      <= 8'h00;
      idx_r     <= 7'h00;
      single_r  <= 1'b0;
      first_r   <= 1'b0;
      left_r    <= 8'h00;
    end else if (start_w) begin
      state_r   <= SM_ADDR;
      bit_cnt_r <= 4'h0;
      ack_r     <= 1'b0;
      sda_oe_r  <= 1'b0;
    end else if (stop_w) begin
      state_r  <= SM_IDLE;
      sda_oe_r <= 1'b0;
    end else if (scl_rise_w && state_r != SM_IDLE) begin
      if (bit_cnt_r != BITS_PER_BYTE) begin
        shreg_r   <= {shreg_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (state_r == SM_RD && !ack_r && sda_s) begin
        state_r <= SM_IDLE;
      end else if (state_r == SM_RD && ack_r && sda_s) begin
        state_r <= SM_IDLE;
      end
    end else if (byte_done_w && state_r != SM_IDLE) begin
      ack_r <= 1'b1;
      case (state_r)
        SM_ADDR: begin
          if (shreg_r[7:1] == addr_r[7:1]) begin
            sda_oe_r <= 1'b1;
            first_r  <= 1'b1;
            state_r  <= shreg_r[0] ? SM_RD : SM_CMD;
          end else begin
            state_r <= SM_IDLE;
          end
        end
        SM_CMD: begin
          sda_oe_r <= 1'b1;
          idx_r    <= shreg_r[6:0];
          single_r <= shreg_r[7];
          left_r   <= 8'h01;
          state_r  <= shreg_r[7] ? SM_WR : SM_CNT;
        end
        SM_CNT: begin
          if (cnt_ok_w) begin
            sda_oe_r <= 1'b1;
            left_r   <= shreg_r;
            state_r  <= SM_WR;
          end else begin
            state_r <= SM_IDLE;
          end
        end
        SM_WR: begin
          sda_oe_r <= 1'b1;
          if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
            idx_r  <= idx_r + 7'h01;
          end
        end
        default: sda_oe_r <= 1'b0;
      endcase
    end else if (scl_fall_w && state_r != SM_IDLE) begin
      if (ack_r) begin
        ack_r     <= 1'b0;
        bit_cnt_r <= 4'h0;
        if (state_r == SM_RD) begin
          tx_r     <= next_tx_w;
          sda_oe_r <= !next_tx_w[7];
          first_r  <= 1'b0;
          if (single_r || !first_r) begin
            idx_r <= idx_r + 7'h01;
          end
        end else begin
          sda_oe_r <= 1'b0;
        end
      end else if (state_r == SM_RD) begin
        sda_oe_r <= !tx_r[~bit_cnt_r[2:0]];
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oe_r   <= OE_RESET;
      mask_r <= MASK_RESET;
      bcnt_r <= BCNT_RESET;
    end else if (wr_en_w) begin
      case (idx_r)
        REG_OE0:   oe_r[19:16] <= shreg_r[OE0_LSB+3:OE0_LSB];
        REG_OE1:   oe_r[7:0] <= shreg_r;
        REG_OE2:   oe_r[15:8] <= shreg_r;
        REG_BCNT:  bcnt_r <= shreg_r;
        REG_MASK0: mask_r[7:0] <= shreg_r;
        REG_MASK1: mask_r[15:8] <= shreg_r;
        REG_MASK2: mask_r[19:16] <= shreg_r[3:0];
        default:   bcnt_r <= bcnt_r;
      endcase
    end
  end

  assign smb_data_out = 1'b0;
  assign smb_data_oe  = sda_oe_r;

  // ****************************************
  // output gating
  // ****************************************
  logic [19:0] want_w;
  logic [19:0] en_r;
  logic [2:0]  hold_r [N_OUT];
  logic        pd_r;

  assign want_w = !pg_s ? 20'h00000
                : sideband_enable_s ? (sb_out_r | mask_r)
                : (oe_r & {7'h7f, ~pins_s, 5'h1f});

  always_ff @(posedge sys_clk) begin
    if (rst || !pg_s) begin
      en_r <= 20'h00000;
      for (int i = 0; i < N_OUT; i++) begin
        hold_r[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < N_OUT; i++) begin
        if (want_w[i]) begin
          en_r[i]   <= 1'b1;
          hold_r[i] <= 3'h0;
        end else if (en_r[i]) begin
          if (hold_r[i] == HOLD_CLOCKS - 3'h1) begin
            en_r[i] <= 1'b0;
          end else begin
            hold_r[i] <= hold_r[i] + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pd_r <= 1'b1;
    end else begin
      pd_r <= !pg_s;
    end
  end

  assign clk_enable = en_r;
  assign power_save = pd_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_resume_fast: assert property ($rose(want_w[7]) |=> clk_enable[7])
    else $error("output 7 did not resume");
  chk_stop_hold: assert property ($fell(want_w[7]) && clk_enable[7] && pg_s
    |-> clk_enable[7] [*4] ##1 !clk_enable[7])
    else $error("output 7 stop timing wrong");
  chk_gate_off: assert property (!want_w[0] [*5] |-> !clk_enable[0])
    else $error("output 0 running without enable");
  chk_pins_ignored: assert property (pg_s && !sideband_enable_s && oe_r[0] |-> want_w[0])
    else $error("pins affected output 0");
  chk_strap_latch: assert property (pg_s && !pg_seen_r
    |=> addr_r == addr_lookup($past(sa1_s), $past(sa0_s)))
    else $error("strap address not latched");
  chk_pdn_disable: assert property ($fell(pg_s) |=> clk_enable == 20'h00000 && power_save)
    else $error("outputs not disabled on power down");
  chk_stable_time: assert property ($rose(pg_s) |=> clk_enable == $past(want_w))
    else $error("outputs not stable after power good");
  chk_bad_count: assert property (byte_done_w && state_r == SM_CNT && !cnt_ok_w && pg_s
    && !start_w && !stop_w |=> state_r == SM_IDLE && !smb_data_oe)
    else $error("bad block count accepted");
  chk_sb_load: assert property (ld_fall_w && sideband_enable_s |=> sb_out_r == $past(sb_shift_r))
    else $error("side-band load missed");
  chk_mask_force: assert property (pg_s && sideband_enable_s && mask_r[3] |-> want_w[3])
    else $error("mask did not force enable");
  chk_no_resp_off: assert property (!pg_s |=> !smb_data_oe)
    else $error("smbus answered while powered down");
  chk_reset_dflt: assert property ($fell(rst) |-> oe_r == OE_RESET && sb_out_r == SB_RESET)
    else $error("enable defaults wrong");

  cov_sb_load: cover property (ld_fall_w && sideband_enable_s);
  cov_read_ack: cover property (state_r == SM_RD && smb_data_oe);
  cov_power_down: cover property ($fell(pg_s) && clk_enable != 20'h00000);
  cov_block_write: cover property (wr_en_w && !single_r);

endmodule // fanout_ctrl

/* tb/sb_host_model.sv */
// side-band controller model that drives the serial enable link
`timescale 1ns/100ps
module sb_host_model (
  // time base and request
  input  wire logic        link_clk,
  input  wire logic        go,
  input  wire logic [19:0] word,
  input  wire logic [4:0]  nbits,
  input  wire logic [2:0]  idle_pins,
  // link pins and status
  output logic             sb_data,
  output logic             sb_clock,
  output logic             sb_load_n,
  output logic             done
);
  logic busy;
  logic d_r;
  logic c_r;
  logic l_r;
  int   i;
  // outside frames the bench owns the pins; load low deselects the device
  assign {sb_load_n, sb_clock, sb_data} = busy ? {l_r, c_r, d_r} : idle_pins;
  initial begin
    busy = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge link_clk);
      if (go && !done) begin
        busy = 1'b1;
        l_r = 1'b1;
        c_r = 1'b0;
        d_r = 1'b0;
        for (i = 0; i < nbits; i++) begin
          @(posedge link_clk);
          d_r = word[i];
          @(posedge link_clk);
          c_r = 1'b1;
          @(posedge link_clk);
          c_r = 1'b0;
          d_r = ~d_r;
        end
        @(posedge link_clk);
        l_r = 1'b0;
        @(posedge link_clk);
        busy = 1'b0;
        done = 1'b1;
      end else if (!go) begin
        done = 1'b0;
      end
    end
  end
endmodule // sb_host_model

/* tb/testbench.sv */
// self-checking bench for the fanout output enable controller
`timescale 1ns/100ps
module testbench;
  import fanout_ctrl_pkg::*;
  logic        sys_clk;
  logic        link_clk;
  logic        rst;
  logic        power_good;
  logic        sideband_enable;
  logic [1:0]  strap0;
  logic [1:0]  strap1;
  logic [2:0]  idle_pins;
  logic [4:0]  pins_other;
  logic        scl_r;
  logic        sda_r;
  logic        go;
  logic [19:0] word;
  logic [4:0]  nbits;
  logic        smb_data_oe;
  logic [19:0] clk_enable;
  logic        power_save;
  logic        sb_data;
  logic        sb_clock;
  logic        sb_load_n;
  logic        done;
  wire         sda = sda_r & ~smb_data_oe;
  logic [19:0] oe_m;
  logic [19:0] mask_m;
  logic [19:0] sbw_m;
  logic [19:0] e;
  logic [7:0]  rd[4];
  logic [7:0]  addr_w;
  logic [7:0]  addr_tab[9] = '{8'hd8, 8'hda, 8'hde, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hce};
  int          errors;
  int          cmp_count;
  int          seed;
  int          k;
  fanout_ctrl i_fanout_ctrl (
    .sys_clk(sys_clk), .rst(rst), .power_good(power_good),
    .addr_select_0(strap0), .addr_select_1(strap1), .sideband_enable(sideband_enable),
    .enable_pin_5_n(sb_data), .enable_pin_6_n(sb_clock), .enable_pin_10_n(sb_load_n),
    .enable_pin_other_n(pins_other), .smb_clock(scl_r), .smb_data_in(sda),
    .smb_data_out(), .smb_data_oe(smb_data_oe), .clk_enable(clk_enable),
    .power_save(power_save));
  sb_host_model i_sb_host_model (
    .link_clk(link_clk), .go(go), .word(word), .nbits(nbits), .idle_pins(idle_pins),
    .sb_data(sb_data), .sb_clock(sb_clock), .sb_load_n(sb_load_n), .done(done));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
  // ****************
  // tasks
  // ****************
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk_vec(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({19'h0, got}, {19'h0, exp});
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_vec({12'h0, got}, {12'h0, exp});
  endtask
  function automatic logic [19:0] exp_en();
    exp_en = oe_m;
    exp_en[12:5] = oe_m[12:5] & ~{pins_other[4:3], sb_load_n, pins_other[2:0], sb_clock, sb_data};
    if (sideband_enable)
      exp_en = sbw_m | mask_m;
    if (!power_good)
      exp_en = 20'h0;
  endfunction
  task automatic smb_bit(input logic b, output logic s);
    cyc(2);
    sda_r <= b;
    cyc(6);
    scl_r <= 1'b1;
    cyc(8);
    s = sda;
    scl_r <= 1'b0;
  endtask
  task automatic smb_byte(input logic [7:0] tx, input logic last, output logic [7:0] r,
                          output logic a);
    logic s;
    for (int j = 7; j >= 0; j--) begin
      smb_bit(tx[j], s);
      r[j] = s;
    end
    smb_bit(last, s);
    a = ~s;
  endtask
  task automatic smb_start();
    cyc(2);
    sda_r <= 1'b1;
    cyc(6);
    scl_r <= 1'b1;
    cyc(8);
    sda_r <= 1'b0;
    cyc(8);
    scl_r <= 1'b0;
  endtask
  task automatic smb_stop();
    cyc(2);
    sda_r <= 1'b0;
    cyc(6);
    scl_r <= 1'b1;
    cyc(8);
    sda_r <= 1'b1;
    cyc(8);
  endtask
  task automatic smb_write(input logic [39:0] b, input int n, input int ok_n);
    logic [7:0] r;
    logic       a;
    smb_start();
    for (int j = 0; j < n; j++) begin
      smb_byte(b[39-8*j -: 8], 1'b1, r, a);
      chk_bit(a, j < ok_n);
    end
    smb_stop();
  endtask
  task automatic smb_read(input logic [7:0] cmd, input int n);
    logic a;
    logic [7:0] r;
    smb_start();
    smb_byte(addr_w, 1'b1, r, a);
    smb_byte(cmd, 1'b1, r, a);
    smb_start();
    smb_byte(addr_w | 8'h01, 1'b1, r, a);
    chk_bit(a, 1'b1);
    for (int j = 0; j < n; j++)
      smb_byte(8'hff, j == n - 1, rd[j], a);
    smb_stop();
  endtask
  task automatic sb_frame(input logic [19:0] w, input logic [4:0] n);
    int t;
    word <= w;
    nbits <= n;
    go <= 1'b1;
    for (t = 0; done !== 1'b1 && t < 400; t++)
      cyc(1);
    go <= 1'b0;
    for (t = t; done !== 1'b0 && t < 400; t++)
      cyc(1);
    if (t >= 400) begin
      errors++;
      stop_test();
    end
    sbw_m = w;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 32'h21abbadd;
    errors = 0;
    cmp_count = 0;
    {rst, power_good, sideband_enable, strap0, strap1, idle_pins, pins_other} = 15'h4000;
    {scl_r, sda_r, go, word, nbits} = 28'hc000000;
    oe_m = 20'hfffff;
    mask_m = 20'h0;
    sbw_m = 20'hfffff;
    for (k = 0; k < 9; k++) begin
      cyc(1);
      rst <= 1'b1;
      power_good <= 1'b0;
      strap1 <= 2'(k / 3);
      strap0 <= 2'(k % 3);
      cyc(5);
      rst <= 1'b0;
      oe_m = 20'hfffff;
      cyc(3);
      chk_bit(power_save, 1'b1);
      power_good <= 1'b1;
      cyc(6);
      strap1 <= 2'h0;
      strap0 <= 2'h0;
      chk_vec(clk_enable, 20'hfffff);
      addr_w = addr_tab[k];
      smb_write({addr_w, 8'h82, 8'h5a, 16'h0}, 3, 3);
      oe_m[15:8] = 8'h5a;
      cyc(11);
      chk_vec(clk_enable, exp_en());
    end
    smb_write({8'hd8, 8'h81, 8'h00, 16'h0}, 3, 0);
    smb_write({addr_w, 8'h01, 8'h00, 8'h12, 8'h0}, 4, 2);
    smb_write({addr_w, 8'h01, 8'h21, 8'h12, 8'h0}, 4, 2);
    smb_write({addr_w, 8'h00, 8'h01, 8'h00, 8'h78}, 5, 5);
    oe_m[19:16] = 4'h0;
    for (k = 0; k < 6; k++) begin
      word = 20'($random(seed));
      smb_write({addr_w, 8'h01, 8'h02, word[15:0]}, 5, 5);
      oe_m[15:0] = {word[7:0], word[15:8]};
      pins_other <= 5'($random(seed));
      idle_pins <= 3'($random(seed));
      cyc(11);
      chk_vec(clk_enable, exp_en());
    end
    smb_read(8'h01, 3);
    chk_byte(rd[0], 8'h08);
    chk_byte(rd[1], oe_m[7:0]);
    chk_byte(rd[2], oe_m[15:8]);
    smb_read(8'h80, 1);
    chk_byte(rd[0], {1'b0, oe_m[19:16], 3'h0});
    smb_write({addr_w, 8'h81, 8'hff, 16'h0}, 3, 3);
    oe_m[7:0] = 8'hff;
    pins_other <= 5'h0;
    idle_pins <= 3'h0;
    cyc(11);
    e = exp_en();
    pins_other <= 5'h01;
    cyc(5);
    chk_vec(clk_enable, e);
    cyc(6);
    chk_vec(clk_enable, exp_en());
    pins_other <= 5'h0;
    cyc(11);
    chk_vec(clk_enable, exp_en());
    power_good <= 1'b0;
    cyc(5);
    chk_vec(clk_enable, 20'h0);
    smb_write({addr_w, 8'h88, 8'hff, 16'h0}, 3, 0);
    sideband_enable <= 1'b1;
    cyc(4);
    sb_frame(20'($random(seed)), 5'd20);
    pins_other <= 5'($random(seed));
    power_good <= 1'b1;
    cyc(8);
    chk_bit(power_save, 1'b0);
    chk_vec(clk_enable, exp_en());
    smb_write({addr_w, 8'h88, 8'h0f, 16'h0}, 3, 3);
    mask_m[7:0] = 8'h0f;
    cyc(11);
    chk_vec(clk_enable, exp_en());
    for (k = 0; k < 10; k++) begin
      idle_pins <= {1'b0, k[0], 1'($random(seed))};
      cyc(2);
    end
    idle_pins <= 3'h0;
    sb_frame(sbw_m, 5'd0);
    cyc(8);
    chk_vec(clk_enable, exp_en());
    sb_frame(20'h00000, 5'd20);
    cyc(8);
    chk_vec(clk_enable, exp_en());
    sideband_enable <= 1'b0;
    cyc(11);
    chk_vec(clk_enable, exp_en());
    stop_test();
  end
endmodule // testbench
